// File: logic/loop_status_monitor_regs.vh
// Word offsets, status field positions, reset values and timing for the
// loop status monitor. Assumes the includer uses these names as given.
`ifndef LOOP_STATUS_MONITOR_REGS_VH
`define LOOP_STATUS_MONITOR_REGS_VH

// ----------------------------------------------------------------------
// Shared word area offsets (word index)
// ----------------------------------------------------------------------
`define ERR_PAIR01_OFFSET   5'h07
`define LOOP1_STATUS_OFFSET 5'h08
`define LOOP2_STATUS_OFFSET 5'h09
`define ERR_PAIR23_OFFSET   5'h11
`define LOOP3_STATUS_OFFSET 5'h12
`define LOOP4_STATUS_OFFSET 5'h13

// ----------------------------------------------------------------------
// Loop status word bit positions
// ----------------------------------------------------------------------
`define ST_SAVE_DONE   15
`define ST_SENSOR_ERR  14
`define ST_CT_OVER     13
`define ST_FATAL       12
`define ST_STANDBY     11
`define ST_PID_DONE    10
`define ST_SET_ERR     9
`define ST_STOP        8
`define ST_CTRL_OUT    4
`define ST_AUTOTUNE    3
`define ST_HEATER_OPEN 2
`define ST_ALARM1      1
`define ST_ALARM2      0

// Setting error word: first loop of a pair high nibble, second low
`define ERR_FIRST_LSB  4
`define ERR_SECOND_LSB 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define STATUS_RESET   16'h0000
`define ERRNUM_RESET   4'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define REF_CLK_HZ        64'd250000000
`define REFRESH_TIMEOUT_S 64'd11
`define REFRESH_TIMEOUT_CYCLES (`REFRESH_TIMEOUT_S * `REF_CLK_HZ)

`endif

// File: logic/loop_status_monitor.v
// Host refresh supervision, front indicators and per-loop status words
// for a four-loop temperature controller. Assumes the control core and
// the host word interface run on REF_CLK; switch and mode pins do not.
`include "loop_status_monitor_regs.vh"
`default_nettype none

module loop_status_monitor
#(
    parameter [63:0] REFRESH_LIMIT = `REFRESH_TIMEOUT_CYCLES,
    parameter        SET_CODES     = 14
)
(
    // Clock and reset
    input  wire                      REF_CLK,
    input  wire                      RST_N,
    // Host refresh and word reads
    input  wire                      EXPLICIT_IO_REFRESH,
    input  wire                      HOST_RD,
    input  wire [4:0]                HOST_ADDR,
    output reg  [15:0]               HOST_RDATA,
    output reg                       HOST_RVALID,
    // Mode pins from outside the clock domain
    input  wire                      STOP_IN_PROGRAM,
    input  wire                      HOST_PROGRAM_MODE,
    // Detected conditions per loop
    input  wire [3:0]                SENSOR_FAULT,
    input  wire [1:0]                CURRENT_TRANSFORMER_OVER,
    input  wire [1:0]                HEATER_OPEN,
    input  wire [4*SET_CODES-1:0]    SET_INVALID,
    // Control core flags per loop
    input  wire [3:0]                SAVE_DONE,
    input  wire [3:0]                FATAL_CTRL,
    input  wire [3:0]                STANDBY,
    input  wire [3:0]                PID_DONE,
    input  wire [3:0]                LOOP_STOP,
    input  wire [3:0]                CTRL_OUT_REQ,
    input  wire [3:0]                AUTOTUNE_FLAG,
    input  wire [3:0]                ALARM_ONE_FLAG,
    input  wire [3:0]                ALARM_TWO_FLAG,
    // Control steering
    output reg  [3:0]                CTRL_OUT,
    output reg  [3:0]                ALARM_OUT_OF_RANGE,
    output reg  [3:0]                HOLD_SETTINGS,
    output reg                       CONTROL_ENABLE,
    // Indicators
    output reg                       RUN_INDICATOR,
    output reg                       UNIT_ERROR_INDICATOR,
    output reg                       HOST_ERROR_INDICATOR
);

    localparam [31:0] limit = REFRESH_LIMIT[31:0];

    // ------------------------------------------------------------------
    // Setting error priority
    // ------------------------------------------------------------------
    // Lowest code wins; scanning downward lets the lowest overwrite last
    function [3:0] set_code;
        input [SET_CODES-1:0] bad;
        integer k;
        begin
            set_code = `ERRNUM_RESET;
            for (k = SET_CODES - 1; k >= 0; k = k - 1)
            begin
                if (bad[k])
                    set_code = k[3:0] + 4'h1;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Both mode pins come from the host side; two stages each keep a
    // metastable level away from the stop logic
    reg [1:0] stop_pin_sync;
    reg [1:0] prog_pin_sync;

    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            stop_pin_sync <= 2'h0;
            prog_pin_sync <= 2'h0;
        end
        else
        begin
            stop_pin_sync <= {stop_pin_sync[0], STOP_IN_PROGRAM};
            prog_pin_sync <= {prog_pin_sync[0], HOST_PROGRAM_MODE};
        end
    end

    wire stopped = stop_pin_sync[1] & prog_pin_sync[1];

    // ------------------------------------------------------------------
    // Host refresh supervision
    // ------------------------------------------------------------------
    // A 32-bit counter holds the full 11 s figure at 250 MHz; the limit
    // is a parameter so simulation can run with a short one.
    reg [31:0] refresh_count;
    reg        host_mon_err;
    reg [31:0] next_refresh_count;
    reg        next_host_mon_err;

    always @*
    begin
        next_refresh_count = refresh_count;
        next_host_mon_err  = host_mon_err;
        // A refresh on the last count still meets the deadline, so the
        // refresh branch is tested first and the error never sets then
        if (EXPLICIT_IO_REFRESH)
        begin
            next_refresh_count = 32'h0000_0000;
            next_host_mon_err  = 1'b0;
        end
        else if (refresh_count >= limit - 32'h1)
        begin
            next_host_mon_err = 1'b1;
        end
        else
        begin
            next_refresh_count = refresh_count + 32'h1;
        end
    end

    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            refresh_count <= 32'h0000_0000;
            host_mon_err  <= 1'b0;
        end
        else
        begin
            refresh_count <= next_refresh_count;
            host_mon_err  <= next_host_mon_err;
        end
    end

    // ------------------------------------------------------------------
    // Per-loop status words
    // ------------------------------------------------------------------
    // One process owns both arrays so each word has a single driver
    reg  [15:0] status_word [0:3];
    reg  [3:0]  err_num     [0:3];
    wire [63:0] next_words;
    wire [15:0] next_codes;
    wire [3:0]  loop_err;
    integer     i;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : loop_gen
            wire ct_over;
            wire heater_open;
            wire [3:0] code;

            if (g < 2)
            begin : with_ct
                assign ct_over     = CURRENT_TRANSFORMER_OVER[g];
                assign heater_open = HEATER_OPEN[g];
            end
            else
            begin : no_ct
                assign ct_over     = 1'b0;
                assign heater_open = 1'b0;
            end

            assign code = set_code(
                SET_INVALID[g*SET_CODES +: SET_CODES]);

            // Flags follow their live causes, so they drop on their own
            assign next_words[g*16 +: 16] = {
                SAVE_DONE[g],
                SENSOR_FAULT[g],
                ct_over,
                FATAL_CTRL[g],
                STANDBY[g],
                PID_DONE[g],
                code != 4'h0,
                LOOP_STOP[g] | stopped,
                3'h0,
                CTRL_OUT_REQ[g] & ~SENSOR_FAULT[g],
                AUTOTUNE_FLAG[g],
                heater_open,
                ALARM_ONE_FLAG[g] | SENSOR_FAULT[g],
                ALARM_TWO_FLAG[g] | SENSOR_FAULT[g]
            };

            assign loop_err[g] = SENSOR_FAULT[g] | ct_over
                               | heater_open | (code != 4'h0);

            assign next_codes[g*4 +: 4] = code;
        end
    endgenerate

    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                status_word[i] <= `STATUS_RESET;
                err_num[i]     <= `ERRNUM_RESET;
            end
        end
        else
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                status_word[i] <= next_words[i*16 +: 16];
                err_num[i]     <= next_codes[i*4 +: 4];
            end
        end
    end

    // ------------------------------------------------------------------
    // Control steering and indicators
    // ------------------------------------------------------------------
    // Host-monitor error deliberately does not enter the enable term
    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CTRL_OUT             <= 4'h0;
            ALARM_OUT_OF_RANGE   <= 4'h0;
            HOLD_SETTINGS        <= 4'h0;
            CONTROL_ENABLE       <= 1'b0;
            RUN_INDICATOR        <= 1'b0;
            UNIT_ERROR_INDICATOR <= 1'b0;
            HOST_ERROR_INDICATOR <= 1'b0;
        end
        else
        begin
            CTRL_OUT             <= CTRL_OUT_REQ & ~SENSOR_FAULT;
            ALARM_OUT_OF_RANGE   <= SENSOR_FAULT;
            HOLD_SETTINGS        <= {
                status_word[3][`ST_SET_ERR],
                status_word[2][`ST_SET_ERR],
                status_word[1][`ST_SET_ERR],
                status_word[0][`ST_SET_ERR]};
            CONTROL_ENABLE       <= ~stopped;
            RUN_INDICATOR        <= ~stopped;
            UNIT_ERROR_INDICATOR <= |loop_err;
            HOST_ERROR_INDICATOR <= host_mon_err;
        end
    end

    // ------------------------------------------------------------------
    // Host word reads
    // ------------------------------------------------------------------
    // Unmapped offsets read zero rather than alias a loop word
    reg [15:0] read_mux;

    always @*
    begin
        case (HOST_ADDR)
            `LOOP1_STATUS_OFFSET: read_mux = status_word[0];
            `LOOP2_STATUS_OFFSET: read_mux = status_word[1];
            `LOOP3_STATUS_OFFSET: read_mux = status_word[2];
            `LOOP4_STATUS_OFFSET: read_mux = status_word[3];
            `ERR_PAIR01_OFFSET:
                read_mux = {8'h00,
                            err_num[0], err_num[1]};
            `ERR_PAIR23_OFFSET:
                read_mux = {8'h00,
                            err_num[2], err_num[3]};
            default:              read_mux = 16'h0000;
        endcase
    end

    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            HOST_RDATA  <= 16'h0000;
            HOST_RVALID <= 1'b0;
        end
        else
        begin
            HOST_RVALID <= HOST_RD;
            if (HOST_RD)
                HOST_RDATA <= read_mux;
        end
    end

endmodule

`default_nettype wire

// File: test/loop_status_monitor_chk.sv
// Assertions on the loop status monitor ports.
// Assumes a short REFRESH_LIMIT so the supervision counter stays small.
`default_nettype none
module loop_status_monitor_chk #(
    parameter [63:0] REFRESH_LIMIT = 64'd20,
    parameter        SET_CODES     = 14
)(
    input wire logic REF_CLK, RST_N, EXPLICIT_IO_REFRESH, HOST_RD,
    input wire logic [4:0] HOST_ADDR,
    input wire logic [15:0] HOST_RDATA,
    input wire logic STOP_IN_PROGRAM, HOST_PROGRAM_MODE,
    input wire logic [3:0] SENSOR_FAULT, CTRL_OUT_REQ, CTRL_OUT,
    input wire logic [1:0] CURRENT_TRANSFORMER_OVER, HEATER_OPEN,
    input wire logic [4*SET_CODES-1:0] SET_INVALID,
    input wire logic CONTROL_ENABLE, RUN_INDICATOR,
    input wire logic UNIT_ERROR_INDICATOR, HOST_ERROR_INDICATOR
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] cnt;
    wire         quiet = ~|{SENSOR_FAULT, CURRENT_TRANSFORMER_OVER,
                            HEATER_OPEN, SET_INVALID};
    wire         stop  = STOP_IN_PROGRAM & HOST_PROGRAM_MODE;
    // Edges since the last refresh, saturating just past the limit
    always_ff @(posedge REF_CLK or negedge RST_N)
        if (!RST_N)
            cnt <= 64'h0;
        else if (EXPLICIT_IO_REFRESH)
            cnt <= 64'h0;
        else if (cnt <= REFRESH_LIMIT)
            cnt <= cnt + 64'h1;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    a_ctrl_out_mask:
        assert property ($past(RST_N) |-> CTRL_OUT == ($past(CTRL_OUT_REQ)
            & ~$past(SENSOR_FAULT))) else $error("output not masked");
    a_unit_err_set:
        assert property (|SENSOR_FAULT |-> ##[1:2] UNIT_ERROR_INDICATOR)
            else $error("unit error not lit");
    a_unit_err_clear:
        assert property (quiet [*3] |=> !UNIT_ERROR_INDICATOR)
            else $error("unit error stuck");
    a_host_err_time:
        assert property (cnt != 64'h0 |-> HOST_ERROR_INDICATOR ==
            (cnt > REFRESH_LIMIT)) else $error("host error timing");
    a_run_ctrl_same:
        assert property (RUN_INDICATOR == CONTROL_ENABLE)
            else $error("control and run differ");
    a_stop_run_off:
        assert property (stop [*3] |=> !RUN_INDICATOR)
            else $error("run lit while stopped");
    a_run_resumes:
        assert property ((!stop) [*3] |=> RUN_INDICATOR)
            else $error("run off while running");
    a_status_zero_bits:
        assert property (HOST_RD && (HOST_ADDR[4:1] == 4'h4 ||
            HOST_ADDR[4:1] == 4'h9) |=> HOST_RDATA[7:5] == 3'h0)
            else $error("reserved status bits set");
    a_upper_loop_zero:
        assert property (HOST_RD && HOST_ADDR[4:1] == 4'h9 |=>
            {HOST_RDATA[13], HOST_RDATA[2]} == 2'b00)
            else $error("absent flag set");
    c_host_err: cover property ($rose(HOST_ERROR_INDICATOR));
    c_stopped: cover property ($fell(RUN_INDICATOR));
    c_unit_err: cover property ($rose(UNIT_ERROR_INDICATOR));
endmodule

bind loop_status_monitor loop_status_monitor_chk #(
    .REFRESH_LIMIT(REFRESH_LIMIT), .SET_CODES(SET_CODES)) i_chk (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .HOST_RD(HOST_RD),
    .EXPLICIT_IO_REFRESH(EXPLICIT_IO_REFRESH), .HOST_ADDR(HOST_ADDR),
    .HOST_RDATA(HOST_RDATA), .STOP_IN_PROGRAM(STOP_IN_PROGRAM),
    .HOST_PROGRAM_MODE(HOST_PROGRAM_MODE), .SENSOR_FAULT(SENSOR_FAULT),
    .CTRL_OUT_REQ(CTRL_OUT_REQ), .CTRL_OUT(CTRL_OUT),
    .CURRENT_TRANSFORMER_OVER(CURRENT_TRANSFORMER_OVER),
    .HEATER_OPEN(HEATER_OPEN), .SET_INVALID(SET_INVALID),
    .CONTROL_ENABLE(CONTROL_ENABLE), .RUN_INDICATOR(RUN_INDICATOR),
    .UNIT_ERROR_INDICATOR(UNIT_ERROR_INDICATOR),
    .HOST_ERROR_INDICATOR(HOST_ERROR_INDICATOR));
`default_nettype wire

// File: test/host_refresh_model.sv
// Host processor model: one-cycle refresh strobe every period cycles.
// Assumes the bench clock; drives off the falling edge like the bench.
`default_nettype none
module host_refresh_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       en,
    input  wire logic [7:0] period,
    output var  logic       refresh = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    // Disabling stands for a host that has stopped refreshing
    always @(negedge clk)
    begin
        if (!rst_n || !en || cnt == period - 8'h01)
            cnt <= 8'h00;
        else
            cnt <= cnt + 8'h01;
        refresh <= rst_n && en && cnt == period - 8'h01;
    end
endmodule
`default_nettype wire

// File: test/loop_status_monitor_tb.sv
// Self-checking bench for the loop status monitor.
// Assumes the bound checker and the host refresh model.
`default_nettype none
module loop_status_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [8:0] fl; logic [3:0] sf; logic [1:0] ct, ho;
        logic [13:0] si; logic [4:0] a; logic [15:0] e; logic u;
    } row_t;
    logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, en = 1'b1;
    logic        sip = 1'b0, pm = 1'b0;
    logic [7:0]  per = 8'h13;
    logic [4:0]  addr = 5'h00;
    logic [3:0]  sf = 4'h0;
    logic [1:0]  ct = 2'h0, ho = 2'h0;
    logic [55:0] si = 56'h0;
    logic [35:0] flg = 36'h0;
    wire         rfr, rvalid, ce, run, uerr, herr;
    wire  [15:0] rdata;
    wire  [3:0]  cout, hold, aoor;
    int          n_mismatch = 0, comparisons = 0;
    row_t rows [9] = '{
        '{9'h1FF, 4'h0, 2'h0, 2'h0, 14'h0, 5'h08, 16'h9D1B, 1'b0},
        '{9'h1FF, 4'h0, 2'h0, 2'h0, 14'h0, 5'h12, 16'h9D1B, 1'b0},
        '{9'h000, 4'hF, 2'h3, 2'h3, 14'h0, 5'h08, 16'h6007, 1'b1},
        '{9'h000, 4'hF, 2'h3, 2'h3, 14'h0, 5'h13, 16'h4003, 1'b1},
        '{9'h000, 4'h0, 2'h0, 2'h0, 14'h6, 5'h09, 16'h0200, 1'b1},
        '{9'h000, 4'h0, 2'h0, 2'h0, 14'h6, 5'h07, 16'h0022, 1'b1},
        '{9'h000, 4'h0, 2'h0, 2'h0, 14'h2000, 5'h11, 16'h00EE, 1'b1},
        '{9'h000, 4'h0, 2'h0, 2'h0, 14'h0, 5'h07, 16'h0000, 1'b0},
        '{9'h000, 4'h0, 2'h0, 2'h0, 14'h0, 5'h1F, 16'h0000, 1'b0}};
    always #2 clk = ~clk;
    loop_status_monitor #(.REFRESH_LIMIT(64'd20)) i_dut (
        .REF_CLK(clk), .RST_N(rst_n), .EXPLICIT_IO_REFRESH(rfr),
        .HOST_RD(rd), .HOST_ADDR(addr), .HOST_RDATA(rdata),
        .HOST_RVALID(rvalid), .STOP_IN_PROGRAM(sip),
        .HOST_PROGRAM_MODE(pm), .SENSOR_FAULT(sf),
        .CURRENT_TRANSFORMER_OVER(ct), .HEATER_OPEN(ho), .SET_INVALID(si),
        .SAVE_DONE(flg[35:32]), .FATAL_CTRL(flg[31:28]),
        .STANDBY(flg[27:24]), .PID_DONE(flg[23:20]), .LOOP_STOP(flg[19:16]),
        .CTRL_OUT_REQ(flg[15:12]), .AUTOTUNE_FLAG(flg[11:8]),
        .ALARM_ONE_FLAG(flg[7:4]), .ALARM_TWO_FLAG(flg[3:0]),
        .CTRL_OUT(cout), .ALARM_OUT_OF_RANGE(aoor), .HOLD_SETTINGS(hold),
        .CONTROL_ENABLE(ce), .RUN_INDICATOR(run),
        .UNIT_ERROR_INDICATOR(uerr), .HOST_ERROR_INDICATOR(herr));
    host_refresh_model i_host (.clk(clk), .rst_n(rst_n), .en(en),
        .period(per), .refresh(rfr));
    task automatic chk(input logic [15:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk(rvalid, 1'b1);
        chk(rdata, e);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        conclude;
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[i])
        begin
            {sf, ct, ho} = {rows[i].sf, rows[i].ct, rows[i].ho};
            si = {4{rows[i].si}};
            for (int k = 0; k < 9; k++)
                flg[k*4 +: 4] = {4{rows[i].fl[k]}};
            repeat (3) @(negedge clk);
            rdchk(rows[i].a, rows[i].e);
            chk(uerr, rows[i].u);
            chk(hold, rows[i].si != 0 ? 4'hF : 4'h0);
            chk(cout, {4{rows[i].fl[3]}} & ~rows[i].sf);
            chk(aoor, rows[i].sf);
        end
        $display("test status rows done");
        // Host refreshing one cycle inside the limit, then silent
        repeat (40) @(negedge clk);
        chk(herr, 1'b0);
        en = 1'b0;
        repeat (25) @(negedge clk);
        chk({herr, run, ce}, 3'b111);
        en = 1'b1;
        repeat (23) @(negedge clk);
        chk(herr, 1'b0);
        $display("test refresh supervision done");
        sip = 1'b1;
        repeat (5) @(negedge clk);
        chk(run, 1'b1);
        pm = 1'b1;
        repeat (4) @(negedge clk);
        chk({run, ce}, 2'b00);
        rdchk(5'h08, 16'h0100);
        sip = 1'b0;
        repeat (4) @(negedge clk);
        chk(run, 1'b1);
        $display("test program stop done");
        sf = 4'h1;
        repeat (3) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        chk({run, uerr, herr}, 3'b000);
        rst_n = 1'b1;
        sf = 4'h0;
        repeat (4) @(negedge clk);
        chk({run, uerr}, 2'b10);
        $display("test mid reset done");
        conclude;
    end
endmodule
`default_nettype wire
